// >>> rtl/iwd_pkg.sv
// Purpose: shared constants and types for the independent watchdog
// Assumes: one clock domain, the 40 kHz watchdog oscillator clock
// Notes: register offsets are word addresses on the plain register port
package iwd_pkg;
  // register map
  localparam logic [3:0] ADDR_KEY = 4'h0;
  localparam logic [3:0] ADDR_PRESC = 4'h1;
  localparam logic [3:0] ADDR_RELOAD = 4'h2;
  localparam logic [3:0] ADDR_WINDOW = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;
  // key values
  localparam logic [15:0] KEY_START = 16'hCCCC;
  localparam logic [15:0] KEY_REFRESH = 16'hAAAA;
  // control bit positions
  localparam int CTRL_TIMER_MODE = 0;
  localparam int CTRL_DBG_FREEZE = 1;
  // status bit positions
  localparam int ST_EXPIRED = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_REFRESH = 2;
  localparam int ST_WIDTH = 3;
  // reset values
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [11:0] RELOAD_RST = 12'hFFF;
  localparam logic [11:0] WINDOW_RST = 12'hFFF;
  // reset pulse length in watchdog clocks
  localparam int RST_PULSE_CYC = 4;
  // time of one cycle at 40 kHz, in ns
  localparam int CLK_PERIOD_NS = 25000;

  typedef enum logic [1:0] {
    IWD_IDLE = 2'b00,
    IWD_RUN = 2'b01,
    IWD_FIRE = 2'b11
  } iwd_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } iwd_bus_type;
endpackage

// >>> rtl/iwd_top.sv
// Purpose: independent watchdog, prescaler plus down counter with refresh window
// Assumes: ref_clk is the dedicated watchdog oscillator, separate from the system clock
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// Operation
// - an 8-bit prescaler divides the clock and each tick decrements a 12-bit counter.
// - software sets a window bound and refreshes are accepted only inside it.
// - the block runs only from its own 40 kHz oscillator clock.
// - nothing here depends on the system clock, so counting goes on in Stop and Standby.
// - in watchdog use a missed service raises the device reset request.
// - in timer mode the counter free-runs and flags timeouts instead of resetting.
// - an option-byte strap picks hardware start or software start.
// - when configured, the counter holds while the core is halted in debug.
`timescale 1ns/100ps
module iwd_top #(
  parameter int PRESC_W = 8,
  parameter int CNT_W = 12
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // option byte and debug
  input wire logic opt_hw_start,
  input wire logic dbg_halt,
  // register port
  input wire iwd_pkg::iwd_bus_type bus,
  output logic [15:0] rdata_ff,
  // outputs
  output logic dev_reset_ff,
  output logic irq_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  iwd_pkg::iwd_state_type state_ff, nxt_state;
  logic [PRESC_W-1:0] presc_ff, div_ff;
  logic [CNT_W-1:0] reload_ff, window_ff, count_ff;
  logic [1:0] ctrl_ff;
  logic [iwd_pkg::ST_WIDTH-1:0] status_ff, irq_en_ff, ev;
  logic strap_done_ff;
  logic [2:0] pulse_ff;
  logic wr_key, key_start, key_refresh, tick, frozen, running;
  logic refresh_ok, refresh_early, expire;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_key = bus.wr && bus.addr == iwd_pkg::ADDR_KEY;
  assign key_start = wr_key && bus.wdata == iwd_pkg::KEY_START;
  assign key_refresh = wr_key && bus.wdata == iwd_pkg::KEY_REFRESH;
  assign running = state_ff == iwd_pkg::IWD_RUN;
  assign frozen = ctrl_ff[iwd_pkg::CTRL_DBG_FREEZE] && dbg_halt;
  // refresh is early while the counter still sits above the window bound
  assign refresh_early = running && key_refresh && count_ff > window_ff;
  assign refresh_ok = running && key_refresh && !refresh_early;
  assign tick = running && !frozen && div_ff == presc_ff;
  assign expire = tick && count_ff == '0 && !refresh_ok;
  assign ev[iwd_pkg::ST_EXPIRED] = expire;
  assign ev[iwd_pkg::ST_EARLY] = refresh_early;
  assign ev[iwd_pkg::ST_REFRESH] = refresh_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // state machine: idle until started, fire holds the reset pulse
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      iwd_pkg::IWD_IDLE: begin
        if (key_start) begin
          nxt_state = iwd_pkg::IWD_RUN;
        end
      end
      iwd_pkg::IWD_RUN: begin
        // timer mode never resets the device, it just wraps
        if (!ctrl_ff[iwd_pkg::CTRL_TIMER_MODE] && (expire || refresh_early)) begin
          nxt_state = iwd_pkg::IWD_FIRE;
        end
      end
      iwd_pkg::IWD_FIRE: begin
        if (pulse_ff == 3'(iwd_pkg::RST_PULSE_CYC - 1)) begin
          nxt_state = iwd_pkg::IWD_RUN;
        end
      end
      default: begin
        nxt_state = iwd_pkg::IWD_IDLE;
      end
    endcase
  end

  // state register; the strap is caught on the first enabled edge after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= iwd_pkg::IWD_IDLE;
      strap_done_ff <= 1'b0;
    end else if (clk_en) begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff && opt_hw_start) begin
        state_ff <= iwd_pkg::IWD_RUN;
      end else begin
        state_ff <= nxt_state;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler: one tick every presc+1 clocks, restarted by a refresh
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (clk_en) begin
      if (!running || refresh_ok || tick) begin
        div_ff <= '0;
      end else if (!frozen) begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

  // down counter; free-running timer wraps to reload at zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= iwd_pkg::RELOAD_RST;
    end else if (clk_en) begin
      if (state_ff != iwd_pkg::IWD_RUN || refresh_ok) begin
        count_ff <= reload_ff;
      end else if (tick) begin
        if (count_ff == '0) begin
          count_ff <= reload_ff;
        end else begin
          count_ff <= count_ff - 1'b1;
        end
      end
    end
  end

  // reset pulse and its length counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= '0;
      dev_reset_ff <= 1'b0;
    end else if (clk_en) begin
      dev_reset_ff <= nxt_state == iwd_pkg::IWD_FIRE;
      if (state_ff == iwd_pkg::IWD_FIRE) begin
        pulse_ff <= pulse_ff + 1'b1;
      end else begin
        pulse_ff <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers; writable in every state, the reset pulse does not lock them
  // a window write acts on the next refresh; a reload write on the next refresh or wrap, and at once outside run
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= iwd_pkg::PRESC_RST;
      reload_ff <= iwd_pkg::RELOAD_RST;
      window_ff <= iwd_pkg::WINDOW_RST;
      ctrl_ff <= '0;
      irq_en_ff <= '0;
    end else if (clk_en && bus.wr) begin
      case (bus.addr)
        iwd_pkg::ADDR_PRESC: presc_ff <= bus.wdata[PRESC_W-1:0];
        iwd_pkg::ADDR_RELOAD: reload_ff <= bus.wdata[CNT_W-1:0];
        iwd_pkg::ADDR_WINDOW: window_ff <= bus.wdata[CNT_W-1:0];
        iwd_pkg::ADDR_CTRL: ctrl_ff <= bus.wdata[1:0];
        iwd_pkg::ADDR_IRQ_EN: irq_en_ff <= bus.wdata[iwd_pkg::ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= '0;
    end else if (clk_en) begin
      if (bus.wr && bus.addr == iwd_pkg::ADDR_IRQ_CLR) begin
        status_ff <= (status_ff & ~bus.wdata[iwd_pkg::ST_WIDTH-1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
    end
  end

  // interrupt level, registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= |(status_ff & irq_en_ff);
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (clk_en) begin
      rdata_ff <= '0;
      if (bus.rd) begin
        case (bus.addr)
          iwd_pkg::ADDR_PRESC: rdata_ff <= 16'(presc_ff);
          iwd_pkg::ADDR_RELOAD: rdata_ff <= 16'(reload_ff);
          iwd_pkg::ADDR_WINDOW: rdata_ff <= 16'(window_ff);
          iwd_pkg::ADDR_CTRL: rdata_ff <= {12'h000, state_ff, ctrl_ff};
          iwd_pkg::ADDR_COUNT: rdata_ff <= 16'(count_ff);
          iwd_pkg::ADDR_STATUS: rdata_ff <= 16'(status_ff);
          iwd_pkg::ADDR_IRQ_EN: rdata_ff <= 16'(irq_en_ff);
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_early_fires: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && refresh_early && !ctrl_ff[0] |=> dev_reset_ff)
    else $error("early refresh did not reset");
  a_refresh_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && refresh_ok |=> count_ff == $past(reload_ff))
    else $error("refresh did not reload");
  a_tick_dec: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && tick && !refresh_ok && count_ff != '0 |=> count_ff == $past(count_ff) - 1'b1)
    else $error("counter did not decrement");
  a_expire_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && expire && !ctrl_ff[0] |=> dev_reset_ff)
    else $error("expiry did not reset");
  a_timer_noreset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_ff[0] && running && clk_en |=> !dev_reset_ff)
    else $error("timer mode reset the device");
  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && frozen && !refresh_ok && running |=> $stable(count_ff))
    else $error("counter moved while frozen");
  a_hw_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !strap_done_ff && opt_hw_start |=> running)
    else $error("hardware start missed");
  a_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_reset_ff) && clk_en |-> dev_reset_ff [*3])
    else $error("reset pulse too short");
  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == iwd_pkg::IWD_IDLE |-> count_ff == reload_ff || $past(bus.wr))
    else $error("idle counter moved");

  ////////////////////////////////////////////////////////////////////////////////
  // further checks on flags, window, timer mode, software start, pulse shape, freezing and interrupt

  // an expiry event always lands in the sticky status
  a_expire_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && expire |=> status_ff[iwd_pkg::ST_EXPIRED])
    else $error("expiry flag not set");

  // an early refresh always lands in the sticky status
  a_early_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && refresh_early |=> status_ff[iwd_pkg::ST_EARLY])
    else $error("early flag not set");

  // a good refresh always lands in the sticky status
  a_good_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && refresh_ok |=> status_ff[iwd_pkg::ST_REFRESH])
    else $error("refresh flag not set");

  // the reset request only ever stands while the machine sits in fire
  a_reset_in_fire: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_reset_ff |-> state_ff == iwd_pkg::IWD_FIRE)
    else $error("reset outside fire state");

  // a refresh at or below the window bound reloads and never resets
  a_window_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && running && key_refresh && count_ff <= window_ff |=>
      count_ff == $past(reload_ff) && !dev_reset_ff)
    else $error("refresh inside window refused");

  // timer mode wraps to the reload value at zero
  a_timer_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && tick && count_ff == '0 && !refresh_ok && ctrl_ff[iwd_pkg::CTRL_TIMER_MODE]
      |=> count_ff == $past(reload_ff))
    else $error("timer did not wrap");

  // timer mode ignores early refreshes as a reset cause
  a_timer_early: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && refresh_early && ctrl_ff[iwd_pkg::CTRL_TIMER_MODE] |=> !dev_reset_ff)
    else $error("timer mode reset on early refresh");

  // software start: after the strap edge only the start key leaves idle
  a_sw_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && strap_done_ff && state_ff == iwd_pkg::IWD_IDLE && !key_start
      |=> state_ff == iwd_pkg::IWD_IDLE)
    else $error("left idle without start key");

  // the pulse is four enabled cycles long and no longer
  a_pulse_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (dev_reset_ff && clk_en) [*4] |=> !dev_reset_ff)
    else $error("reset pulse too long");

  // the prescaler holds too while frozen, so no phase is lost in debug
  a_freeze_div: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && frozen && running && !refresh_ok |=> $stable(div_ff))
    else $error("prescaler moved while frozen");

  // a low clock enable freezes counting and the state machine
  a_enable_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(count_ff) && $stable(state_ff))
    else $error("state moved with enable low");

  // the interrupt follows enabled status with one cycle of lag
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> irq_ff == |($past(status_ff) & $past(irq_en_ff)))
    else $error("interrupt level wrong");

endmodule // iwd_top

// >>> tb/iwd_top_tb.sv
// Purpose: self-checking bench for the independent watchdog through its register port
// Assumes: ref_clk at 25 ns, bench drives all inputs at rising edges by non-blocking assignment
// Notes: count checks use differences between two reads, bar one bounded single read after a refresh, so prescaler phase never matters
`timescale 1ns/100ps
module iwd_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic opt_hw_start = 1'b0;
  logic dbg_halt = 1'b0;
  iwd_pkg::iwd_bus_type bus = '0;
  logic [15:0] rdata_ff;
  logic dev_reset_ff;
  logic irq_ff;
  int error_cnt = 0;
  int checks_done = 0;
  logic [15:0] v1, v2;
  int k, n;

  iwd_top i_iwd_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .opt_hw_start(opt_hw_start), .dbg_halt(dbg_halt), .bus(bus),
    .rdata_ff(rdata_ff), .dev_reset_ff(dev_reset_ff), .irq_ff(irq_ff));

  // free-running clock
  always #12.5 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, released at the taking edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk) bus <= {a, d, 1'b1, 1'b0};
    @(posedge ref_clk) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk) bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk) bus <= '0;
    @(negedge ref_clk) v = rdata_ff;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    rd(a, v1);
    chk(v1, exp);
  endtask

  // two count reads taken two edges apart
  task automatic cnt_diff(input logic [15:0] exp);
    rd(iwd_pkg::ADDR_COUNT, v1);
    rd(iwd_pkg::ADDR_COUNT, v2);
    chk(v1 - v2, exp);
  endtask

  // bounded wait for a reset pulse, then its length in cycles
  task automatic pulse(input int lim);
    k = 0;
    n = 0;
    @(negedge ref_clk);
    while (dev_reset_ff !== 1'b1 && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    while (dev_reset_ff === 1'b1 && n < 9) begin
      n++;
      @(negedge ref_clk);
    end
  endtask

  task automatic do_reset(input logic hw);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    opt_hw_start <= hw;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(30000 * 25);
    error_cnt++;
    report_and_stop();
  end

  // main sequence
  initial begin
    do_reset(1'b0);
    rdc(iwd_pkg::ADDR_PRESC, 16'h0000);
    rdc(iwd_pkg::ADDR_RELOAD, 16'h0FFF);
    rdc(iwd_pkg::ADDR_WINDOW, 16'h0FFF);
    rdc(4'h9, 16'h0000);
    wr(iwd_pkg::ADDR_PRESC, 16'hFFFF);
    rdc(iwd_pkg::ADDR_PRESC, 16'h00FF);
    wr(iwd_pkg::ADDR_PRESC, 16'h0000);
    wr(iwd_pkg::ADDR_RELOAD, 16'hF100);
    rdc(iwd_pkg::ADDR_RELOAD, 16'h0100);
    $display("test regs done");
    // software start strap: idle until started, refresh ignored
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_REFRESH);
    rdc(iwd_pkg::ADDR_STATUS, 16'h0000);
    cnt_diff(16'h0000);
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_START);
    cnt_diff(16'h0002);
    wr(iwd_pkg::ADDR_CTRL, 16'h0002);
    @(posedge ref_clk) dbg_halt <= 1'b1;
    cnt_diff(16'h0000);
    @(posedge ref_clk) dbg_halt <= 1'b0;
    cnt_diff(16'h0002);
    wr(iwd_pkg::ADDR_CTRL, 16'h0000);
    rdc(iwd_pkg::ADDR_CTRL, 16'h0004);
    $display("test start done");
    // refresh inside the window reloads
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_REFRESH);
    rd(iwd_pkg::ADDR_COUNT, v1);
    chk(16'(16'h0100 - v1 < 4), 16'h0001);
    rdc(iwd_pkg::ADDR_STATUS, 16'h0004);
    // refresh above the window fires at once for four cycles
    wr(iwd_pkg::ADDR_WINDOW, 16'h0010);
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_REFRESH);
    pulse(3);
    chk(16'(k), 16'h0000);
    chk(16'(n), 16'h0004);
    rd(iwd_pkg::ADDR_STATUS, v1);
    chk(16'(v1[1]), 16'h0001);
    $display("test window done");
    // no service: expiry after reload plus one ticks
    wr(iwd_pkg::ADDR_WINDOW, 16'h0FFF);
    wr(iwd_pkg::ADDR_RELOAD, 16'h0008);
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_REFRESH);
    pulse(40);
    chk(16'(k < 40), 16'h0001);
    chk(16'(n), 16'h0004);
    rd(iwd_pkg::ADDR_STATUS, v1);
    chk(16'(v1[0]), 16'h0001);
    $display("test expiry done");
    // timer mode flags timeouts without reset
    wr(iwd_pkg::ADDR_CTRL, 16'h0001);
    repeat (6) @(posedge ref_clk);
    pulse(40);
    chk(16'(k), 16'd40);
    wr(iwd_pkg::ADDR_IRQ_EN, 16'h0001);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq_ff), 16'h0001);
    rdc(iwd_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(iwd_pkg::ADDR_IRQ_EN, 16'h0000);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq_ff), 16'h0000);
    wr(iwd_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(iwd_pkg::ADDR_PRESC, 16'h00FF);
    wr(iwd_pkg::ADDR_RELOAD, 16'h0FFF);
    wr(iwd_pkg::ADDR_KEY, iwd_pkg::KEY_REFRESH);
    wr(iwd_pkg::ADDR_IRQ_CLR, 16'h0007);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq_ff), 16'h0000);
    rdc(iwd_pkg::ADDR_STATUS, 16'h0000);
    $display("test timer irq done");
    // hardware start strap runs without a start key
    do_reset(1'b1);
    repeat (2) @(posedge ref_clk);
    cnt_diff(16'h0002);
    // enable low for five edges: only three enabled edges lie between the samples
    rd(iwd_pkg::ADDR_COUNT, v1);
    @(posedge ref_clk) clk_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(iwd_pkg::ADDR_COUNT, v2);
    chk(v1 - v2, 16'h0003);
    $display("test hw start done");
    report_and_stop();
  end
endmodule // iwd_top_tb
